// [cips_pkg.sv]
package cips_pkg;

  // Bus and array widths
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int CHAN_N   = 4;
  localparam int COEFF_AW = 6;

  // Register offsets
  localparam logic [7:0] CONFIG_OFS     = 8'h00;
  localparam logic [7:0] CTRL_ACK_OFS   = 8'h01;
  localparam logic [7:0] COEFF_EN_OFS   = 8'h02;
  localparam logic [7:0] COEFF_ADDR_OFS = 8'h03;
  localparam logic [7:0] COEFF_DATA_OFS = 8'h04;

  // Configuration fields: bit 7 software reset, bits 3:0 channel power-down
  localparam int         CONFIG_REG_SWRST_BIT = 7;
  localparam int         CONFIG_REG_PD_LSB    = 0;
  localparam logic [7:0] CONFIG_RST     = 8'h3F;

  // Control acknowledge fields
  localparam int ACK_INIT_BIT   = 0;
  localparam int ACK_PLL_BIT    = 1;
  localparam int ACK_REFUSE_BIT = 2;

  // Coefficient channel-enable fields: bits 3:0 select, bit 4 RAM power-down
  localparam int         COEN_SEL_LSB = 0;
  localparam int         COEN_PDR_BIT = 4;
  localparam logic [7:0] COEN_RST     = 8'h10;
  localparam logic [7:0] COEN_MASK    = 8'h1F;

  // Other reset values
  localparam logic [5:0] COEFF_ADDR_RST = 6'h00;
  localparam logic [1:0] INIT_CNT_RST   = 2'h0;
  localparam logic [2:0] PLL_CNT_RST    = 3'h0;

  // Timing in frame sync periods
  localparam logic [2:0] PLL_LOCK_FS = 3'h5;
  localparam logic [1:0] INIT_FS     = 2'h2;

  // Initialisation sequencer states
  typedef enum logic [1:0] {
    INIT_WAIT = 2'b00,
    INIT_RUN  = 2'b01,
    INIT_DONE = 2'b10
  } cips_init_e;

  // True when at least one channel is out of power-down
  function automatic logic cips_any_active(input logic [3:0] pd);
    cips_any_active = |(~pd);
  endfunction

endpackage

// [cips_ram_if.sv]
`timescale 1ns/100ps
// Coefficient RAM access group between the sequencer and the RAM banks
interface cips_ram_if;
  logic       we;
  logic [3:0] sel;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [1:0] rchan;
  logic [7:0] rdata;

  modport ctrl (output we, output sel, output addr, output wdata, output rchan, input rdata);
  modport mem  (input we, input sel, input addr, input wdata, input rchan, output rdata);
endinterface

// [cips_fs_counter.sv]
`timescale 1ns/100ps
module cips_fs_counter
  import cips_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic frame_sync_in,
  output logic      fs_tick_out,
  output logic      pll_locked_out
);

  logic       fs_prev_reg;
  logic       fs_tick_reg;
  logic [2:0] pll_cnt_reg;
  logic       pll_lock_reg;
  wire        fs_rise = frame_sync_in & ~fs_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sync edge detect; one-cycle tick per frame period
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      fs_prev_reg <= 1'b0;
      fs_tick_reg <= 1'b0;
    end else begin
      fs_prev_reg <= frame_sync_in;
      fs_tick_reg <= fs_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL lock indication after a fixed number of frames since power-on
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pll_cnt_reg  <= PLL_CNT_RST;
      pll_lock_reg <= 1'b0;
    end else if (fs_tick_reg && !pll_lock_reg) begin
      pll_cnt_reg  <= pll_cnt_reg + 3'h1;
      pll_lock_reg <= (pll_cnt_reg + 3'h1) == PLL_LOCK_FS;
    end
  end

  assign fs_tick_out    = fs_tick_reg;
  assign pll_locked_out = pll_lock_reg;

endmodule // cips_fs_counter

// [cips_coeff_ram.sv]
`timescale 1ns/100ps
module cips_coeff_ram
  import cips_pkg::*;
(
  input  wire logic clk_sys_in,
  cips_ram_if.mem   ram
);

  // One bank per channel
  logic [DATA_W-1:0] mem_bank [0:CHAN_N-1][0:(1<<COEFF_AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // Broadcast write to every selected bank
  always_ff @(posedge clk_sys_in) begin
    for (int c = 0; c < CHAN_N; c++) begin
      if (ram.we && ram.sel[c]) begin
        mem_bank[c][ram.addr] <= ram.wdata;
      end
    end
  end

  // Asynchronous read; the bus slave registers it
  assign ram.rdata = mem_bank[ram.rchan][ram.addr];

endmodule // cips_coeff_ram

// [cips_sequencer.sv]
`timescale 1ns/100ps
// Functional notes
// - Any reset restarts the initialisation program
// - Initialisation advances only with a channel active
// - Done after two frames; then RAM opens with a target selected and the array powered
// - Control acknowledge reads 03 after init and PLL lock, with no refusal pending
// - RAM usable active, or powered down with RAM_POWERDOWN_BIT clear
module cips_sequencer
  import cips_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  input  wire logic              hw_reset_pin_n_in,
  input  wire logic              frame_sync_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  output logic                   init_done_out,
  output logic      [CHAN_N-1:0] channel_active_out,
  output logic                   coeff_ram_ready_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [DATA_W-1:0]   config_reg;
  logic [DATA_W-1:0]   coeff_channel_enable_reg;
  logic [COEFF_AW-1:0] coeff_addr_reg;
  logic [COEFF_AW-1:0] coeff_addr_next;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic                refuse_reg;
  logic                init_done_reg;
  logic [1:0]          init_cnt_reg;
  logic [1:0]          init_cnt_next;
  cips_init_e          init_state_reg;
  cips_init_e          init_state_next;
  logic                fs_tick;
  logic                pll_locked;

  cips_ram_if ram_bus ();

  // Lowest-numbered selected channel answers coefficient reads
  function automatic logic [1:0] cips_first_sel(input logic [3:0] sel);
    cips_first_sel = 2'h0;
    for (int c = CHAN_N - 1; c >= 0; c--) begin
      if (sel[c]) begin
        cips_first_sel = 2'(c);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  cips_fs_counter u_fs (
    .clk_sys_in     (clk_sys_in),
    .sys_rst_in     (sys_rst_in),
    .frame_sync_in  (frame_sync_in),
    .fs_tick_out    (fs_tick),
    .pll_locked_out (pll_locked)
  );

  cips_coeff_ram u_ram (
    .clk_sys_in (clk_sys_in),
    .ram        (ram_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources and channel state decode
  wire       dev_rst    = sys_rst_in | ~hw_reset_pin_n_in;
  wire       sw_rst     = config_reg[CONFIG_REG_SWRST_BIT];
  wire [3:0] chan_pd    = config_reg[CONFIG_REG_PD_LSB +: CHAN_N];
  wire       any_active = cips_any_active(chan_pd);
  wire [3:0] coeff_sel  = coeff_channel_enable_reg[COEN_SEL_LSB +: CHAN_N];
  wire       ram_pdr    = coeff_channel_enable_reg[COEN_PDR_BIT];

  // RAM opens only after init, with a target and a powered array
  wire ram_powered = any_active | ~ram_pdr;
  wire ram_ok      = init_done_reg & (|coeff_sel) & ram_powered;

  // Register bus decode
  wire hit_config = reg_addr_in == CONFIG_OFS;
  wire hit_ack    = reg_addr_in == CTRL_ACK_OFS;
  wire hit_coen   = reg_addr_in == COEFF_EN_OFS;
  wire hit_caddr  = reg_addr_in == COEFF_ADDR_OFS;
  wire hit_cdata  = reg_addr_in == COEFF_DATA_OFS;
  wire wr_config  = reg_wr_in & hit_config;
  wire wr_coen    = reg_wr_in & hit_coen;
  wire wr_caddr   = reg_wr_in & hit_caddr;
  wire wr_cdata   = reg_wr_in & hit_cdata;
  wire rd_ack     = reg_rd_in & hit_ack;
  wire rd_cdata   = reg_rd_in & hit_cdata;
  wire data_acc   = wr_cdata | rd_cdata;
  wire data_ok    = data_acc & ram_ok;
  wire data_bad   = data_acc & ~ram_ok;

  // Control acknowledge image
  wire [7:0] ack_value = {5'h00, refuse_reg, pll_locked, init_done_reg};

  // Read data selection; unmapped offsets read zero
  wire [7:0] rd_cdata_val = ram_ok ? ram_bus.rdata : 8'h00;
  assign rdata_next = !reg_rd_in ? 8'h00 :
                      hit_config ? config_reg :
                      hit_ack    ? ack_value :
                      hit_coen   ? coeff_channel_enable_reg :
                      hit_caddr  ? {2'h0, coeff_addr_reg} :
                      hit_cdata  ? rd_cdata_val : 8'h00;

  // Address steps after each accepted data access
  assign coeff_addr_next = wr_caddr ? reg_wdata_in[COEFF_AW-1:0] :
                           data_ok  ? coeff_addr_reg + 6'h01 : coeff_addr_reg;

  // RAM port drive
  assign ram_bus.we    = wr_cdata & ram_ok;
  assign ram_bus.sel   = coeff_sel;
  assign ram_bus.addr  = coeff_addr_reg;
  assign ram_bus.wdata = reg_wdata_in;
  assign ram_bus.rchan = cips_first_sel(coeff_sel);

  ////////////////////////////////////////////////////////////////////////////
  // Initialisation sequencer next state
  always_comb begin
    init_state_next = init_state_reg;
    init_cnt_next   = init_cnt_reg;
    case (init_state_reg)
      INIT_WAIT: begin
        init_cnt_next = INIT_CNT_RST;
        if (!sw_rst && any_active) begin
          init_state_next = INIT_RUN;
        end
      end
      INIT_RUN: begin
        if (sw_rst) begin
          init_state_next = INIT_WAIT;
        end else if (fs_tick && any_active) begin
          init_cnt_next = init_cnt_reg + 2'h1;
          if ((init_cnt_reg + 2'h1) == INIT_FS) begin
            init_state_next = INIT_DONE;
          end
        end
      end
      INIT_DONE: begin
        if (sw_rst) begin
          init_state_next = INIT_WAIT;
        end
      end
      default: begin
        init_state_next = INIT_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and done flag
  always_ff @(posedge clk_sys_in) begin
    if (dev_rst) begin
      init_state_reg <= INIT_WAIT;
      init_cnt_reg   <= INIT_CNT_RST;
      init_done_reg  <= 1'b0;
    end else begin
      init_state_reg <= init_state_next;
      init_cnt_reg   <= init_cnt_next;
      init_done_reg  <= init_state_next == INIT_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk_sys_in) begin
    if (dev_rst) begin
      config_reg               <= CONFIG_RST;
      coeff_channel_enable_reg <= COEN_RST;
      coeff_addr_reg           <= COEFF_ADDR_RST;
    end else begin
      if (wr_config) begin
        config_reg <= reg_wdata_in;
      end
      if (wr_coen) begin
        coeff_channel_enable_reg <= reg_wdata_in & COEN_MASK;
      end
      coeff_addr_reg <= coeff_addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refused access flag: new refusal wins over the read that clears it
  always_ff @(posedge clk_sys_in) begin
    if (dev_rst) begin
      refuse_reg <= 1'b0;
    end else if (data_bad) begin
      refuse_reg <= 1'b1;
    end else if (rd_ack) begin
      refuse_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (dev_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out       = rdata_reg;
  assign init_done_out       = init_done_reg;
  assign channel_active_out  = ~chan_pd;
  assign coeff_ram_ready_out = ram_ok;

endmodule // cips_sequencer

// [cips_fs_source.sv]
`timescale 1ns/100ps
module cips_fs_source #(
  parameter int FS_PERIOD = 1250,
  parameter int FS_HIGH   = 8
) (
  input  wire logic clk_sys_in,
  output logic      frame_sync_out
);
  int cnt_reg = 0;
  initial frame_sync_out = 1'b0;
  // Free-running 8 kHz frame sync; the host keeps it up while programming
  always @(posedge clk_sys_in) begin
    cnt_reg        <= (cnt_reg == FS_PERIOD - 1) ? 0 : cnt_reg + 1;
    frame_sync_out <= (cnt_reg >= FS_PERIOD - FS_HIGH);
  end
endmodule // cips_fs_source

// [cips_sequencer_assertions.sv]
`timescale 1ns/100ps
module cips_sequencer_assertions
  import cips_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              sys_rst_in,
  input wire logic              hw_reset_pin_n_in,
  input wire logic              frame_sync_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              init_done_out,
  input wire logic [CHAN_N-1:0] channel_active_out,
  input wire logic              coeff_ram_ready_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus steps that start checks
  sequence s_swrst;
    reg_wr_in && reg_addr_in == CONFIG_OFS && reg_wdata_in[CONFIG_REG_SWRST_BIT];
  endsequence
  sequence s_ack_rd;
    reg_rd_in && reg_addr_in == CTRL_ACK_OFS && hw_reset_pin_n_in;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Reset, configuration, initialisation and register access checks
  AST_HW_RST: assert property (!hw_reset_pin_n_in |=> !init_done_out && !(|channel_active_out))
    else $error("pin reset left done or channels set");
  AST_SWRST: assert property (s_swrst |-> ##2 !init_done_out)
    else $error("software reset did not clear done");
  AST_CFG_MAP: assert property (reg_wr_in && reg_addr_in == CONFIG_OFS && hw_reset_pin_n_in
    |=> channel_active_out == ~$past(reg_wdata_in[3:0]))
    else $error("channel active does not follow config write");
  AST_ACK_RD: assert property (s_ack_rd |=> reg_rdata_out[ACK_INIT_BIT] == $past(init_done_out)
    && reg_rdata_out[7:3] == 5'h00)
    else $error("control ack read wrong");
  AST_REFUSE_RD: assert property (reg_rd_in && reg_addr_in == COEFF_DATA_OFS
    && !coeff_ram_ready_out |=> reg_rdata_out == 8'h00)
    else $error("coefficient read leaked while closed");
  AST_RAM_GATE: assert property (coeff_ram_ready_out |-> init_done_out)
    else $error("RAM open before done");
  AST_DONE_ACT: assert property ($rose(init_done_out) |-> |$past(channel_active_out))
    else $error("done rose with no channel active");
  AST_DONE_FS: assert property ($rose(init_done_out) |-> $past(frame_sync_in, 2))
    else $error("done rose away from a frame sync");
endmodule // cips_sequencer_assertions

bind cips_sequencer cips_sequencer_assertions u_chk (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hw_reset_pin_n_in(hw_reset_pin_n_in),
  .frame_sync_in(frame_sync_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .init_done_out(init_done_out), .channel_active_out(channel_active_out),
  .coeff_ram_ready_out(coeff_ram_ready_out)
);

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  import cips_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       pin_n = 1'b1;
  logic       fs;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       done;
  logic [3:0] act;
  logic       ready;
  int         fails = 0;
  int         samples_checked = 0;

  always #50 clk = ~clk;
  cips_fs_source u_fs (.clk_sys_in(clk), .frame_sync_out(fs));
  cips_sequencer u_dut (.clk_sys_in(clk), .sys_rst_in(rst), .hw_reset_pin_n_in(pin_n),
    .frame_sync_in(fs), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .init_done_out(done),
    .channel_active_out(act), .coeff_ram_ready_out(ready));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and compare helpers
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Register bus write and read-compare
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  // Count frame sync rising edges, bounded
  task automatic wait_fs(input int n);
    int k;
    logic p;
    k = 0;
    p = fs;
    for (int i = 0; i < 1300 * n && k < n; i++) begin
      @(posedge clk);
      if (fs && !p) k++;
      p = fs;
    end
    if (k < n) begin
      fails++;
      results();
    end
    repeat (6) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc("cfg", CONFIG_OFS, 8'h3F);
    rdc("coen", COEFF_EN_OFS, 8'h10);
    rdc("unmapped", 8'h07, 8'h00);
    wait_fs(5);
    rdc("ack pll", CTRL_ACK_OFS, 8'h02);
    rdc("coef refused", COEFF_DATA_OFS, 8'h00);
    wrt(COEFF_DATA_OFS, 8'h77);
    rdc("ack refuse", CTRL_ACK_OFS, 8'h06);
    rdc("ack clear", CTRL_ACK_OFS, 8'h02);
    wrt(CONFIG_OFS, 8'hBF);
    wrt(CONFIG_OFS, 8'h3F);
    wait_fs(3);
    chk("done idle", 8'h00, {7'h00, done});
    wrt(CONFIG_OFS, 8'h30);
    chk("active", 8'h0F, {4'h0, act});
    wait_fs(2);
    rdc("ack done", CTRL_ACK_OFS, 8'h03);
    wrt(COEFF_EN_OFS, 8'h11);
    chk("ready", 8'h01, {7'h00, ready});
    wrt(COEFF_ADDR_OFS, 8'h00);
    wrt(COEFF_DATA_OFS, 8'hA5);
    wrt(COEFF_DATA_OFS, 8'h5A);
    rdc("caddr step", COEFF_ADDR_OFS, 8'h02);
    wrt(COEFF_ADDR_OFS, 8'h00);
    rdc("coef0", COEFF_DATA_OFS, 8'hA5);
    rdc("coef1", COEFF_DATA_OFS, 8'h5A);
    wrt(CONFIG_OFS, 8'h3F);
    chk("ready pdr", 8'h00, {7'h00, ready});
    wrt(COEFF_EN_OFS, 8'h01);
    chk("ready pd", 8'h01, {7'h00, ready});
    // Download while every channel is powered down, RAM kept awake
    wrt(COEFF_ADDR_OFS, 8'h05);
    wrt(COEFF_DATA_OFS, 8'h3C);
    wrt(COEFF_ADDR_OFS, 8'h05);
    rdc("coef pd", COEFF_DATA_OFS, 8'h3C);
    wrt(CONFIG_OFS, 8'hB0);
    repeat (2) @(posedge clk);
    #1;
    chk("done swrst", 8'h00, {7'h00, done});
    @(posedge clk);
    pin_n <= 1'b0;
    @(posedge clk);
    pin_n <= 1'b1;
    #1;
    rdc("cfg pin", CONFIG_OFS, 8'h3F);
    rdc("ack pin", CTRL_ACK_OFS, 8'h02);
    results();
  end
endmodule // testbench
